//--- ccrc_top.sv
// Contactless frame CRC unit: appends CRC on transmit, checks and filters on receive.
// Assumes an APB master on mclk_i and byte streams from the framing datapath.
//
// Function
// RULE1 - Transmit enable set appends computed CRC to the frame; clear appends nothing.
// RULE2 - Kind field codes 0,1,2 select CRC5, CRC8, CRC16; code 3 unused.
// RULE3 - Transmit complement bit inverts the CRC before it is appended.
// RULE4 - Transmit preset field bits 6..4 choose the transmit CRC start value.
// RULE5 - Preset codes map to fixed constants per kind; 4, 5 undefined.
// RULE6 - Preset code 6 takes the user start value from nonvolatile storage.
// RULE7 - Receive store bit 7 set writes received CRC bytes to the FIFO.
// RULE8 - Store bit clear keeps received CRC bytes out of the FIFO.
// RULE9 - Host sets store bit when the protocol CRC is not byte aligned.
// RULE10 - Receive preset field bits 6..4 choose receive start value, same codes.
// RULE11 - Receive presets use the same constants; code 7 gives all ones.
// RULE12 - Receive complement bit compares against the inverted computed CRC.
// RULE13 - Receive check enable sets the CRC error flag on mismatch.
// RULE14 - Check disabled still computes the CRC but leaves the error flag.
// RULE15 - Reflected polynomials, data processed least significant bit first.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
module ccrc_top (
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             irq_o,
   // User presets from the configuration store
   input  wire logic [15:0] nv_preset16_i,
   input  wire logic [7:0]  nv_preset8_i,
   input  wire logic [4:0]  nv_preset5_i,
   // Transmit stream in and out
   input  wire logic [7:0]  tx_data_i,
   input  wire logic        tx_valid_i,
   input  wire logic        tx_last_i,
   output logic             tx_ready_o,
   output logic      [7:0]  txo_data_o,
   output logic             txo_valid_o,
   output logic             txo_last_o,
   input  wire logic        txo_ready_i,
   // Receive stream in, FIFO write out
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_valid_i,
   input  wire logic        rx_last_i,
   output logic             rx_ready_o,
   output logic      [7:0]  fifo_data_o,
   output logic             fifo_wr_o
);

   typedef enum logic [1:0] {
      CCRC_TX_DATA = 2'b00,
      CCRC_TX_LO   = 2'b01,
      CCRC_TX_HI   = 2'b10
   } ccrc_tx_e;

   typedef enum logic [1:0] {
      CCRC_RX_RUN   = 2'b00,
      CCRC_RX_FLUSH = 2'b01
   } ccrc_rx_e;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]       tx_cfg_r;
   logic [7:0]       rx_cfg_r;
   logic [2:0]       irq_stat_r;
   logic [2:0]       irq_mask_r;
   logic             rx_err_r;
   logic [15:0]      rx_last_crc_r;
   logic             wr_done;
   logic             rd_done;
   logic             mapped;
   logic [31:0]      rd_mux;
   logic [2:0]       irq_ev;

   ccrc_pkg::ccrc_kind_e tx_kind;
   ccrc_pkg::ccrc_kind_e rx_kind;
   logic             tx_append;
   logic             rx_store;

   assign tx_kind   = ccrc_pkg::ccrc_kind_e'(tx_cfg_r[ccrc_pkg::CFG_KIND_LSB +: 2]);
   assign rx_kind   = ccrc_pkg::ccrc_kind_e'(rx_cfg_r[ccrc_pkg::CFG_KIND_LSB +: 2]);
   assign tx_append = tx_cfg_r[ccrc_pkg::CFG_ON_BIT] && (tx_kind != ccrc_pkg::CCRC_KRSV); // [RULE1] [RULE2]
   assign rx_store  = rx_cfg_r[ccrc_pkg::RX_STORE_BIT];

   assign wr_done = psel_i & penable_i & pready_o & pwrite_i;
   assign rd_done = psel_i & penable_i & pready_o & ~pwrite_i;

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr_i)
         ccrc_pkg::TX_CFG_ADDR:   rd_mux = {24'h000000, tx_cfg_r};
         ccrc_pkg::RX_CFG_ADDR:   rd_mux = {24'h000000, rx_cfg_r};
         ccrc_pkg::IRQ_STAT_ADDR: rd_mux = {29'h0, irq_stat_r};
         ccrc_pkg::IRQ_MASK_ADDR: rd_mux = {29'h0, irq_mask_r};
         ccrc_pkg::RX_STAT_ADDR:  rd_mux = {15'h0000, rx_err_r, rx_last_crc_r};
         default:                 mapped = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // APB answer: one access cycle, data captured in setup
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o  <= psel_i & ~penable_i;
         if (psel_i & ~penable_i) begin
            pslverr_o <= ~mapped;
            prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
         end else begin
            pslverr_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         tx_cfg_r   <= ccrc_pkg::CFG_RST;
         rx_cfg_r   <= ccrc_pkg::CFG_RST;
         irq_mask_r <= ccrc_pkg::IRQ_RST;
      end else if (wr_done) begin
         case (paddr_i)
            ccrc_pkg::TX_CFG_ADDR:   tx_cfg_r   <= pwdata_i[7:0] & ccrc_pkg::TX_CFG_WMASK;
            ccrc_pkg::RX_CFG_ADDR:   rx_cfg_r   <= pwdata_i[7:0] & ccrc_pkg::RX_CFG_WMASK;
            ccrc_pkg::IRQ_MASK_ADDR: irq_mask_r <= pwdata_i[2:0];
            default: ;
         endcase
      end
   end

   // Sticky status, cleared by read; a new event wins over the clear
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_stat_r <= ccrc_pkg::IRQ_RST;
         irq_o      <= 1'b0;
      end else begin
         irq_stat_r <= ((rd_done && paddr_i == ccrc_pkg::IRQ_STAT_ADDR) ? 3'h0 : irq_stat_r)
                       | irq_ev;
         irq_o      <= |(irq_stat_r & irq_mask_r);
      end
   end

   // ------------------------------------------------------------
   // Transmit path
   // ------------------------------------------------------------
   ccrc_step_if tx_step ();
   ccrc_crc_step u_tx_step (.s(tx_step));

   ccrc_tx_e    tx_state_r;
   ccrc_tx_e    tx_state_nxt;
   logic [15:0] tx_crc_r;
   logic [15:0] tx_crc_nxt;
   logic        tx_sof_r;
   logic        tx_sof_nxt;
   logic [7:0]  txo_data_nxt;
   logic        txo_valid_nxt;
   logic        txo_last_nxt;
   logic        tx_done_ev;
   logic [15:0] tx_crc_out;
   logic        tx_slot_free;

   assign tx_step.crc_cur = tx_sof_r ? ccrc_pkg::preset_value(
                               tx_cfg_r[ccrc_pkg::CFG_PRE_LSB +: 3], tx_kind,
                               nv_preset16_i, nv_preset8_i, nv_preset5_i) : tx_crc_r; // [RULE4] [RULE5] [RULE6]
   assign tx_step.data    = tx_data_i;
   assign tx_step.nbits   = 4'h8;
   assign tx_step.kind    = tx_kind;
   assign tx_crc_out      = (tx_crc_r ^ (tx_cfg_r[ccrc_pkg::CFG_INV_BIT] ? 16'hffff : 16'h0000))
                            & ccrc_pkg::kind_mask(tx_kind); // [RULE3]
   assign tx_slot_free    = ~txo_valid_o | txo_ready_i;

   always_comb begin
      tx_state_nxt  = tx_state_r;
      tx_crc_nxt    = tx_crc_r;
      tx_sof_nxt    = tx_sof_r;
      txo_data_nxt  = txo_data_o;
      txo_last_nxt  = txo_last_o;
      txo_valid_nxt = txo_valid_o & ~txo_ready_i;
      tx_done_ev    = 1'b0;
      case (tx_state_r)
         CCRC_TX_DATA: begin
            if (tx_valid_i & tx_ready_o) begin
               txo_data_nxt  = tx_data_i;
               txo_valid_nxt = 1'b1;
               txo_last_nxt  = tx_last_i & ~tx_append; // [RULE1]
               tx_crc_nxt    = tx_step.crc_nxt; // [RULE15]
               tx_sof_nxt    = tx_last_i;
               tx_done_ev    = tx_last_i & ~tx_append;
               if (tx_last_i & tx_append) begin
                  tx_state_nxt = CCRC_TX_LO; // [RULE1]
               end
            end
         end
         CCRC_TX_LO: begin
            if (tx_slot_free) begin
               txo_data_nxt  = tx_crc_out[7:0];
               txo_valid_nxt = 1'b1;
               txo_last_nxt  = (tx_kind != ccrc_pkg::CCRC_K16); // [RULE2]
               tx_done_ev    = (tx_kind != ccrc_pkg::CCRC_K16);
               tx_state_nxt  = (tx_kind == ccrc_pkg::CCRC_K16) ? CCRC_TX_HI : CCRC_TX_DATA;
            end
         end
         CCRC_TX_HI: begin
            if (tx_slot_free) begin
               txo_data_nxt  = tx_crc_out[15:8];
               txo_valid_nxt = 1'b1;
               txo_last_nxt  = 1'b1;
               tx_done_ev    = 1'b1;
               tx_state_nxt  = CCRC_TX_DATA;
            end
         end
         default: tx_state_nxt = CCRC_TX_DATA;
      endcase
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         tx_state_r  <= CCRC_TX_DATA;
         tx_crc_r    <= 16'h0000;
         tx_sof_r    <= 1'b1;
         txo_data_o  <= 8'h00;
         txo_valid_o <= 1'b0;
         txo_last_o  <= 1'b0;
         tx_ready_o  <= 1'b0;
      end else begin
         tx_state_r  <= tx_state_nxt;
         tx_crc_r    <= tx_crc_nxt;
         tx_sof_r    <= tx_sof_nxt;
         txo_data_o  <= txo_data_nxt;
         txo_valid_o <= txo_valid_nxt;
         txo_last_o  <= txo_last_nxt;
         tx_ready_o  <= (tx_state_nxt == CCRC_TX_DATA) & ~txo_valid_nxt;
      end
   end

   // ------------------------------------------------------------
   // Receive path: CRC bytes held back until the frame ends
   // ------------------------------------------------------------
   ccrc_step_if rx_step ();
   ccrc_crc_step u_rx_step (.s(rx_step));

   ccrc_rx_e    rx_state_r;
   ccrc_rx_e    rx_state_nxt;
   logic [15:0] rx_crc_r;
   logic [15:0] rx_crc_nxt;
   logic        rx_sof_r;
   logic        rx_sof_nxt;
   logic [15:0] hold_r;
   logic [15:0] hold_nxt;
   logic [1:0]  cnt_r;
   logic [1:0]  cnt_nxt;
   logic [1:0]  crc_len;
   logic [7:0]  oldest;
   logic        rx_acc;
   logic        rx_full;
   logic [15:0] rx_expect;
   logic [15:0] rx_got;
   logic        rx_bad;
   logic        rx_err_nxt;
   logic [7:0]  fifo_data_nxt;
   logic        fifo_wr_nxt;
   logic        rx_done_ev;
   logic        rx_err_ev;

   assign crc_len = (rx_kind == ccrc_pkg::CCRC_K16) ? 2'd2 : 2'd1;
   assign oldest  = (cnt_r == 2'd2) ? hold_r[15:8] : hold_r[7:0];
   assign rx_acc  = rx_valid_i & rx_ready_o;
   assign rx_full = (cnt_r == crc_len);

   assign rx_step.crc_cur = rx_sof_r ? ccrc_pkg::preset_value(
                               rx_cfg_r[ccrc_pkg::CFG_PRE_LSB +: 3], rx_kind,
                               nv_preset16_i, nv_preset8_i, nv_preset5_i) : rx_crc_r; // [RULE10] [RULE11]
   assign rx_step.data    = oldest;
   assign rx_step.nbits   = (rx_acc & rx_full) ? 4'h8 : 4'h0;
   assign rx_step.kind    = rx_kind;

   assign rx_expect = (rx_step.crc_nxt ^ (rx_cfg_r[ccrc_pkg::CFG_INV_BIT] ? 16'hffff : 16'h0000))
                      & ccrc_pkg::kind_mask(rx_kind); // [RULE12]
   assign rx_got    = ((crc_len == 2'd2) ? {rx_data_i, hold_r[7:0]} : {8'h00, rx_data_i})
                      & ccrc_pkg::kind_mask(rx_kind);
   assign rx_bad    = (rx_expect != rx_got) || (rx_kind == ccrc_pkg::CCRC_KRSV);

   always_comb begin
      rx_state_nxt  = rx_state_r;
      rx_crc_nxt    = rx_crc_r;
      rx_sof_nxt    = rx_sof_r;
      hold_nxt      = hold_r;
      cnt_nxt       = cnt_r;
      fifo_data_nxt = fifo_data_o;
      fifo_wr_nxt   = 1'b0;
      rx_done_ev    = 1'b0;
      rx_err_ev     = 1'b0;
      rx_err_nxt    = rx_err_r;
      case (rx_state_r)
         CCRC_RX_RUN: begin
            if (rx_acc) begin
               rx_crc_nxt = rx_step.crc_nxt; // [RULE14] [RULE15]
               rx_sof_nxt = 1'b0;
               hold_nxt   = {hold_r[7:0], rx_data_i};
               cnt_nxt    = rx_full ? cnt_r : cnt_r + 2'd1;
               if (rx_full) begin
                  fifo_data_nxt = oldest;
                  fifo_wr_nxt   = 1'b1;
               end
               if (rx_last_i) begin
                  rx_done_ev = 1'b1;
                  rx_sof_nxt = 1'b1;
                  if (rx_cfg_r[ccrc_pkg::CFG_ON_BIT]) begin
                     rx_err_ev  = rx_bad; // [RULE13]
                     rx_err_nxt = rx_bad;
                  end
                  if (rx_store) begin
                     rx_state_nxt = CCRC_RX_FLUSH; // [RULE7]
                  end else begin
                     cnt_nxt = 2'd0; // [RULE8]
                  end
               end
            end
         end
         CCRC_RX_FLUSH: begin
            fifo_data_nxt = oldest; // [RULE7]
            fifo_wr_nxt   = (cnt_r != 2'd0);
            cnt_nxt       = (cnt_r != 2'd0) ? cnt_r - 2'd1 : 2'd0;
            if (cnt_r <= 2'd1) begin
               rx_state_nxt = CCRC_RX_RUN;
            end
         end
         default: rx_state_nxt = CCRC_RX_RUN;
      endcase
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_state_r    <= CCRC_RX_RUN;
         rx_crc_r      <= 16'h0000;
         rx_sof_r      <= 1'b1;
         hold_r        <= 16'h0000;
         cnt_r         <= 2'd0;
         fifo_data_o   <= 8'h00;
         fifo_wr_o     <= 1'b0;
         rx_ready_o    <= 1'b0;
         rx_err_r      <= 1'b0;
         rx_last_crc_r <= 16'h0000;
      end else begin
         rx_state_r  <= rx_state_nxt;
         rx_crc_r    <= rx_crc_nxt;
         rx_sof_r    <= rx_sof_nxt;
         hold_r      <= hold_nxt;
         cnt_r       <= cnt_nxt;
         fifo_data_o <= fifo_data_nxt;
         fifo_wr_o   <= fifo_wr_nxt;
         rx_ready_o  <= (rx_state_nxt == CCRC_RX_RUN);
         rx_err_r    <= rx_err_nxt;
         if (rx_done_ev) begin
            rx_last_crc_r <= rx_expect;
         end
      end
   end

   assign irq_ev = {rx_err_ev, rx_done_ev, tx_done_ev};

endmodule

//--- ccrc_pkg.sv
// Package for the contactless frame CRC unit: register map, fields, CRC constants.
// Assumes a 100 MHz single clock domain and an APB register port.
package ccrc_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W         = 8;
   localparam logic [7:0]  TX_CFG_IDX     = 8'h2c;
   localparam logic [7:0]  RX_CFG_IDX     = 8'h2d;
   localparam logic [7:0]  TX_CFG_ADDR    = {TX_CFG_IDX[5:0], 2'b00};
   localparam logic [7:0]  RX_CFG_ADDR    = {RX_CFG_IDX[5:0], 2'b00};
   localparam logic [7:0]  IRQ_STAT_ADDR  = 8'hc0;
   localparam logic [7:0]  IRQ_MASK_ADDR  = 8'hc4;
   localparam logic [7:0]  RX_STAT_ADDR   = 8'hc8;

   // ------------------------------------------------------------
   // Configuration fields, shared by both config registers except the receive store bit
   // ------------------------------------------------------------
   localparam int unsigned CFG_ON_BIT     = 0;
   localparam int unsigned CFG_INV_BIT    = 1;
   localparam int unsigned CFG_KIND_LSB   = 2;
   localparam int unsigned CFG_PRE_LSB    = 4;
   localparam int unsigned RX_STORE_BIT   = 7;
   localparam logic [7:0]  TX_CFG_WMASK   = 8'h7f;
   localparam logic [7:0]  RX_CFG_WMASK   = 8'hff;
   localparam logic [7:0]  CFG_RST        = 8'h00;

   // ------------------------------------------------------------
   // Interrupt status bits
   // ------------------------------------------------------------
   localparam int unsigned IRQ_W          = 3;
   localparam int unsigned IRQ_TX_DONE    = 0;
   localparam int unsigned IRQ_RX_DONE    = 1;
   localparam int unsigned IRQ_RX_ERR     = 2;
   localparam logic [2:0]  IRQ_RST        = 3'h0;

   typedef enum logic [1:0] {
      CCRC_K5   = 2'b00,
      CCRC_K8   = 2'b01,
      CCRC_K16  = 2'b10,
      CCRC_KRSV = 2'b11
   } ccrc_kind_e;

   // ------------------------------------------------------------
   // Polynomials, reflected for LSB-first shifting
   // ------------------------------------------------------------
   localparam logic [15:0] POLY16_REFL    = 16'h8408;
   localparam logic [15:0] POLY8_REFL     = 16'h00b8;
   localparam logic [15:0] POLY5_REFL     = 16'h0012;

   // ------------------------------------------------------------
   // Preset codes and values
   // ------------------------------------------------------------
   localparam logic [2:0]  PRE_ZERO       = 3'h0;
   localparam logic [2:0]  PRE_A          = 3'h1;
   localparam logic [2:0]  PRE_B          = 3'h2;
   localparam logic [2:0]  PRE_C          = 3'h3;
   localparam logic [2:0]  PRE_USER       = 3'h6;
   localparam logic [2:0]  PRE_ONES       = 3'h7;
   localparam logic [15:0] PRE16_A        = 16'h6363;
   localparam logic [15:0] PRE16_B        = 16'ha671;
   localparam logic [15:0] PRE16_C        = 16'hfffe;
   localparam logic [15:0] PRE16_ONES     = 16'hffff;
   localparam logic [7:0]  PRE8_A         = 8'h12;
   localparam logic [7:0]  PRE8_B         = 8'hbf;
   localparam logic [7:0]  PRE8_C         = 8'hfd;
   localparam logic [7:0]  PRE8_ONES      = 8'hff;
   localparam logic [4:0]  PRE5_A         = 5'h12;
   localparam logic [4:0]  PRE5_ONES      = 5'h1f;

   function automatic logic [15:0] kind_mask(input ccrc_kind_e k);
      case (k)
         CCRC_K16: kind_mask = 16'hffff;
         CCRC_K8:  kind_mask = 16'h00ff;
         CCRC_K5:  kind_mask = 16'h001f;
         default:  kind_mask = 16'h0000;
      endcase
   endfunction

   // Start value of the CRC register for a preset code and kind
   function automatic logic [15:0] preset_value(input logic [2:0]  code,
                                                input ccrc_kind_e  k,
                                                input logic [15:0] nv16,
                                                input logic [7:0]  nv8,
                                                input logic [4:0]  nv5);
      logic [15:0] v16;
      logic [7:0]  v8;
      logic [4:0]  v5;
      v16 = 16'h0000;
      v8  = 8'h00;
      v5  = 5'h00;
      case (code)
         PRE_A: begin
            v16 = PRE16_A;
            v8  = PRE8_A;
            v5  = PRE5_A;
         end
         PRE_B: begin
            v16 = PRE16_B;
            v8  = PRE8_B;
         end
         PRE_C: begin
            v16 = PRE16_C;
            v8  = PRE8_C;
         end
         PRE_USER: begin
            v16 = nv16;
            v8  = nv8;
            v5  = nv5;
         end
         PRE_ONES: begin
            v16 = PRE16_ONES;
            v8  = PRE8_ONES;
            v5  = PRE5_ONES;
         end
         default: ;
      endcase
      case (k)
         CCRC_K16: preset_value = v16;
         CCRC_K8:  preset_value = {8'h00, v8};
         CCRC_K5:  preset_value = {11'h000, v5};
         default:  preset_value = 16'h0000;
      endcase
   endfunction

endpackage

//--- ccrc_step_if.sv
// Interface between the CRC unit and one bit-serial CRC stepper.
// Assumes a purely combinational stepper on the far side.
`timescale 1ns/10ps
interface ccrc_step_if;
   logic [15:0]          crc_cur;
   logic [7:0]           data;
   logic [3:0]           nbits;
   ccrc_pkg::ccrc_kind_e kind;
   logic [15:0]          crc_nxt;

   modport host (output crc_cur, output data, output nbits, output kind, input crc_nxt);
   modport eng  (input crc_cur, input data, input nbits, input kind, output crc_nxt);
endinterface

//--- ccrc_crc_step.sv
// Combinational CRC stepper: feeds up to eight data bits, LSB first.
// Assumes the CRC register holds zero above the width of the kind.
`timescale 1ns/10ps
module ccrc_crc_step (
   ccrc_step_if.eng s
);

   always_comb begin
      logic [15:0] c;
      logic [15:0] poly;
      logic        fb;
      c  = s.crc_cur & ccrc_pkg::kind_mask(s.kind);
      fb = 1'b0;
      poly = 16'h0000;
      case (s.kind)
         ccrc_pkg::CCRC_K16: poly = ccrc_pkg::POLY16_REFL;
         ccrc_pkg::CCRC_K8:  poly = ccrc_pkg::POLY8_REFL;
         ccrc_pkg::CCRC_K5:  poly = ccrc_pkg::POLY5_REFL;
         default:            poly = 16'h0000;
      endcase
      for (int i = 0; i < 8; i++) begin
         if (i < int'(s.nbits)) begin
            fb = c[0] ^ s.data[i];
            c  = c >> 1;
            if (fb) begin
               c = c ^ poly;
            end
         end
      end
      s.crc_nxt = c & ccrc_pkg::kind_mask(s.kind);
   end

endmodule

//--- ccrc_sink.sv
// Transmit sink model: takes output bytes, promptly or with stalls.
// Assumes one clock and an active high asynchronous reset.
`timescale 1ns/10ps
module ccrc_sink (
   input  wire logic mclk_i,
   input  wire logic reset_i,
   input  wire logic slow_i,
   output logic      ready_o
);
   logic [1:0] cnt_r;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) cnt_r <= 2'h0;
      else cnt_r <= cnt_r + 2'h1;
   end
   // Slow mode accepts one cycle in four
   assign ready_o = !slow_i || cnt_r == 2'h3;
endmodule

//--- ccrc_props.sv
// Port checker for ccrc_top: register bus answer, transmit handshake, reset release.
// Assumes one clock domain; bound to every ccrc_top instance.
`timescale 1ns/10ps
module ccrc_props (
   input wire logic        mclk_i,
   input wire logic        reset_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic [7:0]  tx_data_i,
   input wire logic        tx_valid_i,
   input wire logic        tx_ready_o,
   input wire logic [7:0]  txo_data_o,
   input wire logic        txo_valid_o,
   input wire logic        txo_last_o,
   input wire logic        txo_ready_i,
   input wire logic        rx_ready_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   a_apb_answer: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no answer after setup");
   a_ready_once: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   a_err_rdata: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
      else $error("error without ready or nonzero data");
   a_tx_pass: assert property (tx_valid_i && tx_ready_o |=>
      txo_valid_o && txo_data_o == $past(tx_data_i)) else $error("byte not passed");
   a_tx_hold: assert property (txo_valid_o && !txo_ready_i |=>
      txo_valid_o && $stable(txo_data_o) && $stable(txo_last_o)) else $error("output dropped");
   a_tx_busy: assert property (txo_valid_o |-> !tx_ready_o)
      else $error("input taken while output pending");
   a_tx_gap: assert property (txo_valid_o && txo_ready_i && txo_last_o |=> !txo_valid_o)
      else $error("output after final byte");
   a_ready_rel: assert property ($fell(reset_i) |=> tx_ready_o && rx_ready_o)
      else $error("streams not ready after reset");
endmodule

bind ccrc_top ccrc_props u_props (.mclk_i, .reset_i, .psel_i, .penable_i, .prdata_o,
   .pready_o, .pslverr_o, .tx_data_i, .tx_valid_i, .tx_ready_o, .txo_data_o,
   .txo_valid_o, .txo_last_o, .txo_ready_i, .rx_ready_o);

//--- tb_contactless_frame_crc_unit.sv
// Testbench for ccrc_top: registers, CRC append, CRC check and store, interrupt.
// Assumes ccrc_sink as transmit sink; bytes are shared by both input streams.
`timescale 1ns/10ps
`define CK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_contactless_frame_crc_unit;
   logic        mclk_i = 0, reset_i = 1, psel = 0, pen = 0, pwr = 0, txv = 0, rxv = 0;
   logic        sl = 0, slow = 0, mk = 0, er, prdy, perr, irq, txr, tov, tol, tor, rxr, fw;
   logic [7:0]  pa = 0, sd = 0, nv8 = 8'h3c, tod, fd;
   logic [31:0] pwd = 0, rd, prd;
   logic [15:0] nv16 = 16'h1d0f;
   logic [4:0]  nv5 = 5'h0b;
   logic [8:0]  tq [$];
   logic [7:0]  fq [$];
   int          n_errors = 0, checks = 0, wd = 0;

   ccrc_top DUT (.mclk_i, .reset_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
      .irq_o(irq), .nv_preset16_i(nv16), .nv_preset8_i(nv8), .nv_preset5_i(nv5),
      .tx_data_i(sd), .tx_valid_i(txv), .tx_last_i(sl), .tx_ready_o(txr), .txo_data_o(tod),
      .txo_valid_o(tov), .txo_last_o(tol), .txo_ready_i(tor), .rx_data_i(sd),
      .rx_valid_i(rxv), .rx_last_i(sl), .rx_ready_o(rxr), .fifo_data_o(fd), .fifo_wr_o(fw));
   ccrc_sink SINK (.mclk_i, .reset_i, .slow_i(slow), .ready_o(tor));

   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      wd++;
      if (tov && tor) tq.push_back({tol, tod});
      if (fw) fq.push_back(fd);
      if (wd == 8000) begin
         n_errors++;
         close_out();
      end
   end

   function automatic logic [15:0] msk(input logic [1:0] k);
      return k == 2'h2 ? 16'hffff : k == 2'h1 ? 16'h00ff : 16'h001f;
   endfunction
   function automatic logic [15:0] pre(input logic [2:0] s, input logic [1:0] k);
      case (s)
         3'h1: pre = k == 2'h2 ? 16'h6363 : 16'h0012;
         3'h2: pre = k == 2'h2 ? 16'ha671 : {8'h00, k[0] ? 8'hbf : 8'h00};
         3'h3: pre = k == 2'h2 ? 16'hfffe : {8'h00, k[0] ? 8'hfd : 8'h00};
         3'h6: pre = k == 2'h2 ? nv16 : k[0] ? {8'h00, nv8} : {11'h000, nv5};
         3'h7: pre = msk(k);
         default: pre = 16'h0000;
      endcase
   endfunction
   // Two fixed data bytes, LSB first, optional complement
   function automatic logic [15:0] crc(input logic [7:0] cfg);
      logic [15:0] c;
      logic [15:0] p;
      logic [15:0] d;
      c = pre(cfg[6:4], cfg[3:2]);
      p = cfg[3:2] == 2'h2 ? 16'h8408 : cfg[3:2] == 2'h1 ? 16'h00b8 : 16'h0012;
      d = 16'hc35a;
      for (int i = 0; i < 16; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ p : c >> 1;
      return cfg[1] ? c ^ msk(cfg[3:2]) : c;
   endfunction

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
      @(posedge mclk_i);
      pen <= 1'b1;
      do @(posedge mclk_i); while (!prdy);
      rd = prd;
      er = perr;
      psel <= 1'b0; pen <= 1'b0;
   endtask
   task automatic put(input logic rx, input logic [7:0] d, input logic l);
      @(posedge mclk_i);
      rxv <= rx; txv <= !rx; sd <= d; sl <= l;
      do @(posedge mclk_i); while (!(rx ? rxr : txr));
      rxv <= 1'b0; txv <= 1'b0;
   endtask

   task automatic tx_frame(input logic [7:0] cfg);
      logic [15:0] c;
      int          n;
      c = crc(cfg);
      n = !cfg[0] ? 2 : cfg[3:2] == 2'h2 ? 4 : 3;
      apb(1'b1, 8'hb0, {24'h0, cfg});
      tq.delete();
      put(1'b0, 8'h5a, 1'b0);
      put(1'b0, 8'hc3, 1'b1);
      wait (tq.size() == n);
      repeat (4) @(posedge mclk_i);
      `CK(tq.size(), n)
      `CK(tq[1], {n == 2, 8'hc3})
      if (n > 2) `CK(tq[2], {n == 3, c[7:0]})
      if (n > 3) `CK(tq[3], {1'b1, c[15:8]})
   endtask
   task automatic rx_frame(input logic [7:0] cfg, input logic bad);
      logic [15:0] c;
      c = crc(cfg) ^ {15'h0, bad};
      apb(1'b1, 8'hb4, {24'h0, cfg});
      fq.delete();
      put(1'b1, 8'h5a, 1'b0);
      put(1'b1, 8'hc3, 1'b0);
      put(1'b1, c[7:0], cfg[3:2] != 2'h2);
      if (cfg[3:2] == 2'h2) put(1'b1, c[15:8], 1'b1);
      repeat (6) @(posedge mclk_i);
      `CK(irq, bad & cfg[0] & mk)
      apb(1'b0, 8'hc0, 32'h0);
      `CK(rd[2:0], {bad & cfg[0], 2'b10})
      `CK(fq.size(), cfg[7] ? (cfg[3:2] == 2'h2 ? 4 : 3) : 2)
      if (cfg[7]) `CK(fq[2], c[7:0])
      repeat (2) @(posedge mclk_i);
      `CK(irq, 1'b0)
   endtask

   task close_out;
      $display("n_errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge mclk_i);
      reset_i <= 1'b0;
      apb(1'b0, 8'hb0, 32'h0);
      `CK(rd, 32'h0)
      apb(1'b1, 8'hb0, 32'hff);
      apb(1'b0, 8'hb0, 32'h0);
      `CK(rd, 32'h7f)
      apb(1'b0, 8'h10, 32'h0);
      `CK({er, rd}, 33'h1_0000_0000)
      for (int i = 0; i < 6; i++) begin
         slow <= i[0];
         tx_frame(i == 0 ? 8'h7b : i == 1 ? 8'h15 : i == 2 ? 8'h61 :
                  i == 3 ? 8'h29 : i == 4 ? 8'h37 : 8'h7a);
      end
      apb(1'b0, 8'hc0, 32'h0);
      apb(1'b1, 8'hc4, 32'h4);
      mk = 1'b1;
      rx_frame(8'h7b, 1'b0);
      rx_frame(8'hf7, 1'b0);
      rx_frame(8'he1, 1'b0);
      rx_frame(8'h15, 1'b1);
      rx_frame(8'h04, 1'b1);
      apb(1'b1, 8'hc4, 32'h0);
      mk = 1'b0;
      rx_frame(8'h39, 1'b1);
      close_out();
   end
endmodule
